// file: rtl/dskip_exec.sv
// Execution of decrement-and-skip-if-zero / decrement-and-skip-if-nonzero
// Notes on behaviour
// - Read the addressed file register and subtract one to form the result.
// - Destination bit 0 writes the accumulator; 1 writes back to the file register.
// - Skip-if-zero variant discards the fetched next instruction when the result is zero.
// - Skip-if-nonzero variant discards the fetched next instruction on a nonzero result.
// - One cycle without skip, two cycles when a skip discards a one-word instruction, three when it discards a two-word one.
// - Bank bit 0 uses the access bank; 1 uses the bank select register.
// - Bank bit 0, extended set on, address up to 95 selects indexed literal offset.
`timescale 1ns/1ps
module dskip_exec
(
  input  wire logic                         clk,          // Core clock, 40 MHz
  input  wire logic                         rst,          // Synchronous reset, active high
  input  wire logic                         start,        // Decoded instruction valid, pulse
  input  wire dskip_pkg::dskip_variant_t    variant,      // Zero or nonzero skip variant
  input  wire logic [dskip_pkg::FILE_W-1:0] file_addr,    // 8-bit file operand
  input  wire logic                         dest_bit,     // Destination select
  input  wire logic                         bank_bit,     // Bank access select
  input  wire logic [dskip_pkg::BANK_W-1:0] bank_select_register, // Current bank
  input  wire logic                         ext_en,       // Extended instruction set enabled
  input  wire logic [dskip_pkg::ADDR_W-1:0] index_base,   // Base for indexed literal offset
  input  wire logic                         next_two_word, // Fetched next is two words
  input  wire logic [dskip_pkg::DATA_W-1:0] mem_rdata,    // Data memory read data, 1 cycle
  output logic                              busy,         // Instruction in progress
  output logic                              mem_rd,       // Data memory read strobe
  output logic                              mem_wr,       // Data memory write strobe
  output logic [dskip_pkg::ADDR_W-1:0]      mem_addr,     // Data memory address
  output logic [dskip_pkg::DATA_W-1:0]      mem_wdata,    // Data memory write data
  output logic                              acc_we,       // Accumulator write strobe
  output logic [dskip_pkg::DATA_W-1:0]      acc_wdata,    // Accumulator write data
  output logic                              discard,      // Replace fetched word by no-op
  output logic                              done,         // Instruction retired, pulse
  output logic [1:0]                        cycles_used,  // Cycle cost of last instruction
  output logic                              skipped,      // Last instruction skipped
  output logic                              indexed_used  // Last operand used indexed mode
);

  // ***************************************************************
  // Signals
  // ***************************************************************
  dskip_pkg::dskip_state_t        state_reg;
  dskip_pkg::dskip_state_t        state_next;
  dskip_pkg::dskip_variant_t      variant_reg;
  logic                           dest_reg;
  logic                           two_word_reg;
  logic [dskip_pkg::ADDR_W-1:0]   addr_reg;
  logic                           indexed_reg;
  logic [dskip_pkg::DATA_W-1:0]   result;
  logic                           take_skip;
  logic [1:0]                     skip_left_reg;
  logic [1:0]                     cost_reg;

  dskip_addr_if ai ();

  // ***************************************************************
  // Address former
  // ***************************************************************
  assign ai.file_addr  = file_addr;
  assign ai.bank_bit   = bank_bit;
  assign ai.bank_sel   = bank_select_register;
  assign ai.ext_en     = ext_en;
  assign ai.index_base = index_base;

  dskip_addr_form u_addr_form
  (
    .ai (ai.former)
  );

  // ***************************************************************
  // Result and skip decision
  // ***************************************************************
  // Result comes straight from the returned read data in the execute cycle
  assign result    = mem_rdata - 8'h01;
  assign take_skip = (variant_reg == dskip_pkg::VAR_SKIP_ZERO)
                     ? (result == 8'h00)
                     : (result != 8'h00);

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  // Next state: each skipped program word costs one further cycle
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      dskip_pkg::ST_IDLE:
      begin
        if (start)
        begin
          state_next = dskip_pkg::ST_READ;
        end
      end
      dskip_pkg::ST_READ:
      begin
        state_next = dskip_pkg::ST_EXEC;
      end
      dskip_pkg::ST_EXEC:
      begin
        state_next = take_skip ? dskip_pkg::ST_SKIP : dskip_pkg::ST_IDLE;
      end
      dskip_pkg::ST_SKIP:
      begin
        if (skip_left_reg == 2'd1)
        begin
          state_next = dskip_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = dskip_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= dskip_pkg::ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Capture decoded fields; operand address is frozen so bank changes mid-flight are harmless
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      variant_reg  <= dskip_pkg::VAR_SKIP_ZERO;
      dest_reg     <= dskip_pkg::DEST_FILE;
      two_word_reg <= 1'b0;
      addr_reg     <= '0;
      indexed_reg  <= 1'b0;
    end
    else if ((state_reg == dskip_pkg::ST_IDLE) && start)
    begin
      variant_reg  <= variant;
      dest_reg     <= dest_bit;
      two_word_reg <= next_two_word;
      addr_reg     <= ai.data_addr;
      indexed_reg  <= ai.indexed;
    end
  end

  // Count of skip cycles still owed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      skip_left_reg <= 2'd0;
    end
    else if ((state_reg == dskip_pkg::ST_EXEC) && take_skip)
    begin
      skip_left_reg <= two_word_reg ? 2'd2 : 2'd1;
    end
    else if (state_reg == dskip_pkg::ST_SKIP)
    begin
      skip_left_reg <= skip_left_reg - 2'd1;
    end
  end

  // ***************************************************************
  // Memory and accumulator writes
  // ***************************************************************
  // Strobes and data registered; write lands one cycle after execute
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      acc_we    <= 1'b0;
      acc_wdata <= '0;
    end
    else
    begin
      mem_rd <= (state_reg == dskip_pkg::ST_IDLE) && start;
      mem_wr <= (state_reg == dskip_pkg::ST_EXEC) && (dest_reg == dskip_pkg::DEST_FILE);
      acc_we <= (state_reg == dskip_pkg::ST_EXEC) && (dest_reg == dskip_pkg::DEST_ACC);
      if ((state_reg == dskip_pkg::ST_IDLE) && start)
      begin
        mem_addr <= ai.data_addr;
      end
      else
      begin
        mem_addr <= addr_reg;
      end
      if (state_reg == dskip_pkg::ST_EXEC)
      begin
        mem_wdata <= result;
        acc_wdata <= result;
      end
    end
  end

  // ***************************************************************
  // Skip, cost and completion
  // ***************************************************************
  // Discard covers every skip cycle so the fetch side drops each word
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      discard <= 1'b0;
    end
    else
    begin
      discard <= ((state_reg == dskip_pkg::ST_EXEC) && take_skip)
                 || ((state_reg == dskip_pkg::ST_SKIP) && (skip_left_reg == 2'd2));
    end
  end

  // Cost of the instruction in progress
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cost_reg <= dskip_pkg::CYCLES_NO_SKIP;
    end
    else if (state_reg == dskip_pkg::ST_EXEC)
    begin
      cost_reg <= !take_skip ? dskip_pkg::CYCLES_NO_SKIP
                : two_word_reg ? dskip_pkg::CYCLES_SKIP_TWO
                : dskip_pkg::CYCLES_SKIP;
    end
  end

  // Retire: done pulse and sticky summary of the last instruction
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done         <= 1'b0;
      cycles_used  <= '0;
      skipped      <= 1'b0;
      indexed_used <= 1'b0;
    end
    else
    begin
      done <= ((state_reg == dskip_pkg::ST_EXEC) && !take_skip)
              || ((state_reg == dskip_pkg::ST_SKIP) && (skip_left_reg == 2'd1));
      if ((state_reg == dskip_pkg::ST_EXEC) && !take_skip)
      begin
        cycles_used  <= dskip_pkg::CYCLES_NO_SKIP;
        skipped      <= 1'b0;
        indexed_used <= indexed_reg;
      end
      else if ((state_reg == dskip_pkg::ST_SKIP) && (skip_left_reg == 2'd1))
      begin
        cycles_used  <= cost_reg;
        skipped      <= 1'b1;
        indexed_used <= indexed_reg;
      end
    end
  end

  // Busy is combinational so decode sees it in the start cycle's successor
  assign busy = (state_reg != dskip_pkg::ST_IDLE);

endmodule

// file: rtl/dskip_pkg.sv
// Shared constants and types for the decrement-and-skip execution block
package dskip_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILE_W = 8;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned ADDR_W = 12;

  // ***************************************************************
  // Addressing constants
  // ***************************************************************
  localparam logic [FILE_W-1:0] INDEXED_MAX_F   = 8'h5F;  // Highest offset for indexed mode
  localparam logic [FILE_W-1:0] ACCESS_SPLIT_F  = 8'h60;  // Access bank low/high split
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK  = 4'h0;   // Low half of access bank
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK  = 4'hF;   // High half of access bank
  localparam logic              DEST_ACC        = 1'b0;   // Result to accumulator
  localparam logic              DEST_FILE       = 1'b1;   // Result back to file register
  localparam logic              BANK_ACCESS     = 1'b0;   // Operand in access bank
  localparam logic              BANK_SELECTED   = 1'b1;   // Operand in selected bank

  // ***************************************************************
  // Cycle costs
  // ***************************************************************
  localparam logic [1:0] CYCLES_NO_SKIP  = 2'd1;
  localparam logic [1:0] CYCLES_SKIP     = 2'd2;
  localparam logic [1:0] CYCLES_SKIP_TWO = 2'd3;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_EXEC  = 4'b0100,
    ST_SKIP  = 4'b1000
  } dskip_state_t;

  typedef enum logic
  {
    VAR_SKIP_ZERO    = 1'b0,
    VAR_SKIP_NONZERO = 1'b1
  } dskip_variant_t;

endpackage

// file: rtl/dskip_addr_if.sv
// Operand addressing signals between the executor and its address former
`timescale 1ns/1ps
interface dskip_addr_if;
  logic [dskip_pkg::FILE_W-1:0] file_addr;
  logic                         bank_bit;
  logic [dskip_pkg::BANK_W-1:0] bank_sel;
  logic                         ext_en;
  logic [dskip_pkg::ADDR_W-1:0] index_base;
  logic [dskip_pkg::ADDR_W-1:0] data_addr;
  logic                         indexed;

  modport exec
  (
    output file_addr,
    output bank_bit,
    output bank_sel,
    output ext_en,
    output index_base,
    input  data_addr,
    input  indexed
  );

  modport former
  (
    input  file_addr,
    input  bank_bit,
    input  bank_sel,
    input  ext_en,
    input  index_base,
    output data_addr,
    output indexed
  );
endinterface

// file: rtl/dskip_addr_form.sv
// Forms the data memory address of the file operand
`timescale 1ns/1ps
module dskip_addr_form
(
  dskip_addr_if.former ai  // Addressing request and result
);

  // ***************************************************************
  // Address selection
  // ***************************************************************
  // Indexed mode only reaches the low part of the access bank window
  always_comb
  begin
    ai.indexed = (ai.bank_bit == dskip_pkg::BANK_ACCESS) && ai.ext_en
                 && (ai.file_addr <= dskip_pkg::INDEXED_MAX_F);
    if (ai.bank_bit == dskip_pkg::BANK_SELECTED)
    begin
      ai.data_addr = {ai.bank_sel, ai.file_addr};
    end
    else if (ai.indexed)
    begin
      ai.data_addr = ai.index_base + {4'h0, ai.file_addr};
    end
    else if (ai.file_addr < dskip_pkg::ACCESS_SPLIT_F)
    begin
      ai.data_addr = {dskip_pkg::ACCESS_LO_BANK, ai.file_addr};
    end
    else
    begin
      ai.data_addr = {dskip_pkg::ACCESS_HI_BANK, ai.file_addr};
    end
  end

endmodule

// file: tb/dskip_mem_model.sv
// Behavioural data memory on the far side of the executor
`timescale 1ns/1ps
module dskip_mem_model
(
  input  wire logic        clk,   // Core clock
  input  wire logic        rd,    // Read strobe
  input  wire logic        wr,    // Write strobe
  input  wire logic [11:0] addr,  // Byte address
  input  wire logic [7:0]  wdata, // Write data
  output logic      [7:0]  rdata  // Read data, valid the cycle after rd
);
  logic [7:0] mem [0:4095];
  initial rdata = 8'h3C;
  // Outside the valid cycle the data toggles, so a late sample never matches
  always @(posedge clk)
  begin
    rdata <= rd ? mem[addr] : ~rdata;
    if (wr)
      mem[addr] <= wdata;
  end
endmodule

// file: tb/dskip_exec_checker.sv
// Port-level assertions for the decrement-and-skip executor
`timescale 1ns/1ps
module dskip_exec_checker
(
  input wire logic        clk,                  // Core clock
  input wire logic        rst,                  // Synchronous reset
  input wire logic        start,                // Instruction valid
  input wire dskip_pkg::dskip_variant_t variant, // Skip variant
  input wire logic [7:0]  file_addr,            // File operand
  input wire logic        dest_bit,             // Destination select
  input wire logic        bank_bit,             // Bank access select
  input wire logic [3:0]  bank_select_register, // Current bank
  input wire logic        ext_en,               // Extended set on
  input wire logic [11:0] index_base,           // Indexed base
  input wire logic        next_two_word,        // Next is two words
  input wire logic [7:0]  mem_rdata,            // Read data
  input wire logic        busy,                 // In progress
  input wire logic        mem_rd,               // Read strobe
  input wire logic        mem_wr,               // Write strobe
  input wire logic [11:0] mem_addr,             // Data address
  input wire logic [7:0]  mem_wdata,            // Write data
  input wire logic        acc_we,               // Accumulator strobe
  input wire logic [7:0]  acc_wdata,            // Accumulator data
  input wire logic        discard,              // Word discarded
  input wire logic        done,                 // Retired
  input wire logic [1:0]  cycles_used,          // Cycle cost
  input wire logic        skipped,              // Skip flag
  input wire logic        indexed_used          // Indexed flag
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_go;
    start && !busy;
  endsequence
  sequence s_idx;
    s_go ##0 !bank_bit && ext_en && file_addr <= 8'h5F;
  endsequence
  read_strobe_a:
    assert property (s_go |=> mem_rd ##1 !mem_rd)
      else $error("operand read strobe wrong");
  dec_result_a:
    assert property (s_go ##3 1 |-> (mem_wr ? mem_wdata : acc_wdata) == $past(mem_rdata) - 8'h01)
      else $error("result is not operand minus one");
  dest_sel_a:
    assert property (s_go ##3 1 |-> mem_wr == $past(dest_bit, 3) && acc_we == !$past(dest_bit, 3))
      else $error("result went to wrong place");
  skip_zero_a:
    assert property (s_go ##0 !variant ##3 1 |-> discard == ($past(mem_rdata) == 8'h01))
      else $error("zero variant skip wrong");
  skip_nonzero_a:
    assert property (s_go ##0 variant ##3 1 |-> discard == ($past(mem_rdata) != 8'h01))
      else $error("nonzero variant skip wrong");
  one_cycle_a:
    assert property (s_go ##3 !discard |-> done && !busy && cycles_used == 2'h1 && !skipped)
      else $error("no-skip cost wrong");
  two_cycle_a:
    assert property (s_go ##0 !next_two_word ##3 discard |=>
      done && !discard && cycles_used == 2'h2)
      else $error("skip cost wrong");
  two_word_a:
    assert property (s_go ##0 next_two_word ##3 discard |=>
      discard && !done ##1 done && cycles_used == 2'h3)
      else $error("two-word skip cost wrong");
  bank_addr_a:
    assert property (s_go ##0 bank_bit |=>
      mem_addr == {$past(bank_select_register), $past(file_addr)})
      else $error("selected bank address wrong");
  access_addr_a:
    assert property (s_go ##0 !bank_bit && !(ext_en && file_addr <= 8'h5F) |=>
      mem_addr == {($past(file_addr) < 8'h60) ? 4'h0 : 4'hF, $past(file_addr)})
      else $error("access bank address wrong");
  indexed_addr_a:
    assert property (s_idx |=> mem_addr == $past(index_base) + {4'h0, $past(file_addr)})
      else $error("indexed address wrong");
endmodule

bind dskip_exec dskip_exec_checker i_dskip_exec_checker (.clk, .rst, .start, .variant,
  .file_addr, .dest_bit, .bank_bit, .bank_select_register, .ext_en, .index_base,
  .next_two_word, .mem_rdata, .busy, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .acc_we,
  .acc_wdata, .discard, .done, .cycles_used, .skipped, .indexed_used);

// file: tb/test_decrement_and_skip_exec.sv
// Self-checking bench for the decrement-and-skip executor
`timescale 1ns/1ps
module test_decrement_and_skip_exec;
  logic                      clk, rst, start, dest_bit, bank_bit, ext_en, next_two_word;
  dskip_pkg::dskip_variant_t variant;
  logic [7:0]                file_addr, mem_rdata, mem_wdata, acc_wdata;
  logic [3:0]                bank_select_register;
  logic [11:0]               index_base, mem_addr;
  logic                      busy, mem_rd, mem_wr, acc_we, discard, done, skipped, indexed_used;
  logic [1:0]                cycles_used;
  int                        err_count, check_count;

  dskip_exec i_dskip_exec (.clk, .rst, .start, .variant, .file_addr, .dest_bit, .bank_bit,
    .bank_select_register, .ext_en, .index_base, .next_two_word, .mem_rdata, .busy, .mem_rd,
    .mem_wr, .mem_addr, .mem_wdata, .acc_we, .acc_wdata, .discard, .done, .cycles_used,
    .skipped, .indexed_used);
  dskip_mem_model i_dskip_mem_model (.clk, .rd(mem_rd), .wr(mem_wr), .addr(mem_addr),
    .wdata(mem_wdata), .rdata(mem_rdata));

  // ********
  // Clock, compare and verdict
  // ********
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [11:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ********
  // One instruction against the reference model
  // ********
  // Returns in the done cycle, so the next call starts back to back
  task automatic run(input logic v, input logic [7:0] f, val, input logic d, a, e, two, poke);
    logic [11:0] ad;
    logic [7:0]  res;
    logic        sk;
    int          cyc, lat, nw, na, nd;
    bank_select_register = 4'($urandom);
    index_base = 12'($urandom);
    ad = a ? {bank_select_register, f} : (e && f <= 8'h5F) ? index_base + {4'h0, f}
       : {(f < 8'h60) ? 4'h0 : 4'hF, f};
    res = val - 8'h01;
    sk = v ? (res != 8'h00) : (res == 8'h00);
    cyc = sk ? (two ? 3 : 2) : 1;
    {lat, nw, na, nd} = '0;
    variant = dskip_pkg::dskip_variant_t'(v);
    {file_addr, dest_bit, bank_bit, ext_en, next_two_word, start} = {f, d, a, e, two, 1'b1};
    for (int k = 1; k < 9 && lat == 0; k++)
    begin
      @(posedge clk);
      #2;
      // Operand goes in after the start edge, once the previous write has landed
      if (k == 1)
        i_dskip_mem_model.mem[ad] = val;
      // A start while busy must be ignored; the operand changes to expose it
      if (k < 3)
        start = (k == 1) && poke;
      if (k == 1 && poke)
        file_addr = ~f;
      nw += mem_wr;
      na += acc_we;
      nd += discard;
      if (done)
        lat = k;
    end
    chk("latency", 12'(cyc + 2), 12'(lat));
    chk("cycles_used", 12'(cyc), {10'h000, cycles_used});
    chk("skipped", {11'h000, sk}, {11'h000, skipped});
    chk("discards", 12'(cyc - 1), 12'(nd));
    chk("strobes", {10'h000, d, !d}, 12'({nw[0], na[0]} | ((nw + na - 1) << 2)));
    chk("result", {4'h0, res}, {4'h0, d ? mem_wdata : acc_wdata});
    chk("address", ad, mem_addr);
    chk("indexed", {11'h000, !a && e && f <= 8'h5F}, {11'h000, indexed_used});
  endtask

  // ********
  // Tests
  // ********
  initial
  begin
    err_count = 0;
    check_count = 0;
    {rst, start, dest_bit, bank_bit, ext_en, next_two_word} = 6'b100000;
    variant = dskip_pkg::VAR_SKIP_ZERO;
    {file_addr, bank_select_register, index_base} = '0;
    void'($urandom(32'h91f3));
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    @(posedge clk);
    #2;
    // Both variants, both results, both destinations, split points 5F and 60
    for (int i = 0; i < 16; i++)
      run(i[0], i[0] ? 8'h5F : 8'h60, i[3] ? 8'h01 : 8'h00, i[1], i[3] ^ i[1],
          1'b1, i[2], i[2]);
    $display("directed test done");
    for (int i = 0; i < 200; i++)
      run(1'($urandom), 8'($urandom), ($urandom % 4 == 0) ? 8'h01 : 8'($urandom), 1'($urandom),
          1'($urandom), 1'($urandom), 1'($urandom), $urandom % 5 == 0);
    $display("random test done");
    final_report();
  end

  // Far longer than the 216 instructions need
  initial
  begin
    #200_000;
    err_count++;
    final_report();
  end
endmodule
